// ### rtl/link_sync3.sv
// three-stage synchroniser with agreement filter
// assumes asynchronous inputs; output moves only when stages two and three agree
`timescale 1ns/1ps
module link_sync3 #(
	parameter int unsigned   W    = 1,
	parameter logic [W-1:0]  INIT = '0
)(
	input  wire logic         clk,   // sampling clock
	input  wire logic         rst_n, // active-low reset
	input  wire logic [W-1:0] d,     // asynchronous input
	output logic      [W-1:0] q      // filtered output
);
	logic [W-1:0] s1_r;
	logic [W-1:0] s2_r;
	logic [W-1:0] s3_r;
	logic [W-1:0] agree;

	assign agree = ~(s2_r ^ s3_r);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s1_r <= INIT;
			s2_r <= INIT;
			s3_r <= INIT;
			q    <= INIT;
		end else begin
			s1_r <= d;
			s2_r <= s1_r;
			s3_r <= s2_r;
			q    <= (s3_r & agree) | (q & ~agree);
		end
	end
endmodule // link_sync3

// ### rtl/nor_pe_pkg.sv
// constants, types and carriers of the program/erase/suspend sequencer
// assumes a 100 MHz sequencer clock; no other package is needed
package nor_pe_pkg;

	// ----------------------------------------------------------------
	// clock and times
	// ----------------------------------------------------------------
	localparam int unsigned CLK_MHZ    = 100;
	localparam int unsigned PP_US      = 500;     // page_program_time
	localparam int unsigned SSE_US     = 50000;   // subsector_erase_time
	localparam int unsigned SE_US      = 500000;  // sector_erase_time
	localparam int unsigned BE_US      = 2000000; // bulk_erase_time
	localparam int unsigned SUSP_LAT_US = 20;
	localparam logic [31:0] PP_CYC_DEF  = 32'(PP_US * CLK_MHZ);
	localparam logic [31:0] SSE_CYC_DEF = 32'(SSE_US * CLK_MHZ);
	localparam logic [31:0] SE_CYC_DEF  = 32'(SE_US * CLK_MHZ);
	localparam logic [31:0] BE_CYC_DEF  = 32'(BE_US * CLK_MHZ);
	localparam logic [11:0] LAT_CYC     = 12'(SUSP_LAT_US * CLK_MHZ);

	// ----------------------------------------------------------------
	// opcodes
	// ----------------------------------------------------------------
	localparam logic [7:0] OPC_PP3  = 8'h02;
	localparam logic [7:0] OPC_QP3  = 8'h32;
	localparam logic [7:0] OPC_PP4  = 8'h12;
	localparam logic [7:0] OPC_QP4  = 8'h34;
	localparam logic [7:0] OPC_SSE  = 8'h20;
	localparam logic [7:0] OPC_SSE2 = 8'h52;
	localparam logic [7:0] OPC_SE   = 8'hD8;
	localparam logic [7:0] OPC_BE   = 8'hC7;
	localparam logic [7:0] OPC_BE2  = 8'h60;
	localparam logic [7:0] OPC_SUSP = 8'h75;
	localparam logic [7:0] OPC_RES  = 8'h7A;
	localparam logic [7:0] OPC_CLRF = 8'h50;
	localparam logic [7:0] OPC_WREN = 8'h06;
	localparam logic [7:0] OPC_WRDI = 8'h04;
	localparam logic [7:0] OPC_EN4  = 8'hB7;
	localparam logic [7:0] OPC_EX4  = 8'hE9;

	// ----------------------------------------------------------------
	// flag status fields and misc
	// ----------------------------------------------------------------
	localparam logic [7:0] FSR_RST  = 8'h80;
	localparam logic [7:0] FSR_PEC  = 8'h80;
	localparam logic [7:0] FSR_ESUS = 8'h40;
	localparam logic [7:0] FSR_EERR = 8'h20;
	localparam logic [7:0] FSR_PERR = 8'h10;
	localparam logic [7:0] FSR_PSUS = 8'h04;
	localparam logic [7:0] FSR_PROT = 8'h02;
	localparam logic [7:0] ERASE_FILL = 8'hFF;
	localparam int unsigned SECT_SHIFT = 16;

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef enum logic [4:0] {
		OP_NONE = 5'b00001,
		OP_PROG = 5'b00010,
		OP_SSE  = 5'b00100,
		OP_SE   = 5'b01000,
		OP_BE   = 5'b10000
	} op_kind_e;

	typedef enum logic [3:0] {
		ST_IDLE = 4'b0001,
		ST_RUN  = 4'b0010,
		ST_LAT  = 4'b0100,
		ST_SUSP = 4'b1000
	} pe_state_e;

	typedef struct packed {
		logic       sclk;
		logic       cs_n;
		logic [3:0] dq;
	} link_s;

	typedef struct packed {
		logic        valid;
		op_kind_e    kind;
		logic [31:0] addr;
		logic [7:0]  fill;
	} array_cmd_s;

	localparam link_s LINK_IDLE = '{sclk: 1'h0, cs_n: 1'h1, dq: 4'h0};

endpackage

// ### rtl/nor_program_erase_suspend_ctrl.sv
// serial flash program/erase/suspend command sequencer
// assumes link pins asynchronous to ref_clk; array, protection on ref_clk
`timescale 1ns/1ps
// Summary of operation
// - accept 4-byte page and quad program opcodes with 32-bit address
// - dedicated 4-byte opcodes always use 4 address bytes; others follow mode
// - address mode from nonvolatile strap or enter/exit commands
// - accepted program runs self-timed for the page program time
// - erase only sets bits, fill value all ones
// - erase without write enable latch is ignored, no flags
// - select released mid-byte: nothing executes, no flags, latch kept
// - erase of protected subsector refused, latch kept, flag bits 1 and 5
// - erase running: controller flag 0, write-in-progress 1, then 0
// - latch cleared at end of every erase
// - timeout clears latch and sets erase error flag, or program error flag (bit 4) for a program
// - decode subsector, sector, bulk erase; any address inside target
// - bulk erase refused if any sector locked, flag bits 1 and 5
// - subsector and sector erase may be suspended and resumed
// - erase duration selected by command kind
// - suspend halts active program, subsector or sector erase within suspend latency; bulk erase ignores it
// - suspend sets flag bit 2 for program, bit 6 for erase
// - after latency flag bit 7 set; host waits to read it
// - too little time left: finish instead, clear bit 2 or 6
// - suspend state volatile, flag status resets to 80h
// - one nesting level: program inside suspended erase, resumed in order
// - resume ignored when nothing is suspended
// - program into erase-suspended sector ignored, flag bit 4, latch kept
// - clear flag status resets erase, program, protection errors
module nor_program_erase_suspend_ctrl
	import nor_pe_pkg::*;
#(
	parameter logic [31:0] PP_CYC  = PP_CYC_DEF,  // program duration
	parameter logic [31:0] SSE_CYC = SSE_CYC_DEF, // subsector erase duration
	parameter logic [31:0] SE_CYC  = SE_CYC_DEF,  // sector erase duration
	parameter logic [31:0] BE_CYC  = BE_CYC_DEF   // bulk erase duration
)(
	input  wire logic  ref_clk,      // 100 MHz clock
	input  wire logic  nrst,         // async reset, active low
	input  wire link_s link,         // serial clock, select, data lines
	input  wire logic  nv_addr4,     // nonvolatile 4-byte mode setting
	input  wire logic  prot_hit,     // frame_addr_r lies in protected area
	input  wire logic  any_locked,   // some sector locked
	input  wire logic  op_fault,     // array timeout pulse
	output logic       wel_r,        // write enable latch
	output logic       wip_r,        // write in progress
	output logic [7:0] fsr_r,        // flag status
	output logic       addr4_r,      // 4-byte address mode
	output logic [31:0] frame_addr_r, // address of current frame
	output array_cmd_s array_cmd_r,  // start of an array operation
	output logic       array_run_r   // array may advance current op
);
	// ----------------------------------------------------------------
	// reset release
	// ----------------------------------------------------------------
	logic [1:0] rst_q_r;
	logic       rst_n;

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst)
			rst_q_r <= 2'h0;
		else
			rst_q_r <= {rst_q_r[0], 1'h1};
	end
	assign rst_n = rst_q_r[1];

	// ----------------------------------------------------------------
	// link sampling
	// ----------------------------------------------------------------
	link_s link_f;
	link_s link_p_r;
	logic  sclk_rise;
	logic  cs_fall;
	logic  cs_rise;

	link_sync3 #(.W(6), .INIT(LINK_IDLE)) u_sync (
		.clk   (ref_clk),
		.rst_n (rst_n),
		.d     (link),
		.q     (link_f)
	);

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n)
			link_p_r <= LINK_IDLE;
		else
			link_p_r <= link_f;
	end

	assign sclk_rise = link_f.sclk & ~link_p_r.sclk & ~link_f.cs_n;
	assign cs_fall   = ~link_f.cs_n & link_p_r.cs_n;
	assign cs_rise   = link_f.cs_n & ~link_p_r.cs_n;

	// ----------------------------------------------------------------
	// frame assembly
	// ----------------------------------------------------------------
	logic [2:0] bitpos_r;
	logic [2:0] nbytes_r;
	logic [7:0] sr_r;
	logic [7:0] opc_r;
	logic       is4;
	logic [2:0] alen;
	logic       quadph;
	logic [2:0] bp_nxt;
	logic [7:0] sr_nxt;

	always_comb begin
		is4    = (opc_r == OPC_PP4) || (opc_r == OPC_QP4);
		alen   = (is4 || addr4_r) ? 3'h4 : 3'h3;
		quadph = ((opc_r == OPC_QP4) || (opc_r == OPC_QP3)) && (nbytes_r > alen);
		bp_nxt = bitpos_r + (quadph ? 3'h4 : 3'h1);
		sr_nxt = quadph ? {sr_r[3:0], link_f.dq} : {sr_r[6:0], link_f.dq[0]};
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			bitpos_r     <= 3'h0;
			nbytes_r     <= 3'h0;
			sr_r         <= 8'h00;
			opc_r        <= 8'h00;
			frame_addr_r <= 32'h0;
		end else if (cs_fall) begin
			bitpos_r     <= 3'h0;
			nbytes_r     <= 3'h0;
			frame_addr_r <= 32'h0;
		end else if (sclk_rise) begin
			bitpos_r <= bp_nxt;
			sr_r     <= sr_nxt;
			if (bp_nxt == 3'h0) begin
				if (nbytes_r != 3'h7)
					nbytes_r <= nbytes_r + 3'h1;
				if (nbytes_r == 3'h0)
					opc_r <= sr_nxt;
				else if (nbytes_r <= alen)
					frame_addr_r <= {frame_addr_r[23:0], sr_nxt};
			end
		end
	end

	// ----------------------------------------------------------------
	// command decode
	// ----------------------------------------------------------------
	logic     is_prog;
	logic     is_erase;
	op_kind_e ers_kind;
	logic [31:0] ers_cyc;
	logic [2:0] need;
	logic     frame_ok;

	always_comb begin
		is_prog  = (opc_r == OPC_PP3) || (opc_r == OPC_QP3) ||
		           (opc_r == OPC_PP4) || (opc_r == OPC_QP4);
		is_erase = 1'h1;
		ers_kind = OP_NONE;
		ers_cyc  = 32'h0;
		case (opc_r)
			OPC_SSE, OPC_SSE2: begin
				ers_kind = OP_SSE;
				ers_cyc  = SSE_CYC;
			end
			OPC_SE: begin
				ers_kind = OP_SE;
				ers_cyc  = SE_CYC;
			end
			OPC_BE, OPC_BE2: begin
				ers_kind = OP_BE;
				ers_cyc  = BE_CYC;
			end
			default: is_erase = 1'h0;
		endcase
		if (is_prog)
			need = alen + 3'h2;
		else if (is_erase && ers_kind != OP_BE)
			need = alen + 3'h1;
		else
			need = 3'h1;
		// a frame counts only when select rises on a byte boundary
		frame_ok = cs_rise && (bitpos_r == 3'h0) && (nbytes_r >= need);
	end

	// ----------------------------------------------------------------
	// sequencing events
	// ----------------------------------------------------------------
	pe_state_e   st_r;
	op_kind_e    cur_kind_r;
	op_kind_e    held_kind_r;
	logic [31:0] cur_addr_r;
	logic [31:0] held_addr_r;
	logic [31:0] held_rem_r;
	logic        held_r;
	logic        late_r;
	logic [11:0] lat_r;
	logic [31:0] t_rem;
	logic        t_done;
	logic        tload;
	logic [31:0] tval;
	logic [7:0]  fset;
	logic [7:0]  fclr;
	logic        go_prog;
	logic        go_nest;
	logic        go_erase;
	logic        go_lat;
	logic        go_late;
	logic        go_res;
	logic        go_end;
	logic        lat_done;
	logic        cur_is_prog;

	always_comb begin
		fset     = 8'h00;
		fclr     = 8'h00;
		go_prog  = 1'h0;
		go_nest  = 1'h0;
		go_erase = 1'h0;
		go_lat   = 1'h0;
		go_late  = 1'h0;
		go_res   = 1'h0;
		tload    = 1'h0;
		tval     = 32'h0;
		cur_is_prog = (cur_kind_r == OP_PROG);
		go_end   = (st_r == ST_RUN) && (t_done || op_fault);
		lat_done = (st_r == ST_LAT) && (lat_r == 12'h0);
		if (go_end) begin
			fset = fset | FSR_PEC;
			if (late_r)
				fclr = fclr | (cur_is_prog ? FSR_PSUS : FSR_ESUS);
			if (op_fault)
				fset = fset | (cur_is_prog ? FSR_PERR : FSR_EERR);
			if (held_r) begin
				tload = 1'h1;
				tval  = held_rem_r;
			end
		end
		if (lat_done)
			fset = fset | FSR_PEC;
		if (frame_ok) begin
			if (is_prog && wel_r &&
			    (st_r == ST_IDLE || (st_r == ST_SUSP && !cur_is_prog))) begin
				if (st_r == ST_SUSP &&
				    frame_addr_r[31:SECT_SHIFT] == cur_addr_r[31:SECT_SHIFT])
					fset = fset | FSR_PERR;
				else if (prot_hit)
					fset = fset | FSR_PROT | FSR_PERR;
				else begin
					go_prog = 1'h1;
					go_nest = (st_r == ST_SUSP);
					tload   = 1'h1;
					tval    = PP_CYC;
					fclr    = fclr | FSR_PEC;
				end
			end
			// latch clear means the erase is dropped with no flag
			if (is_erase && wel_r && st_r == ST_IDLE) begin
				if ((ers_kind == OP_BE) ? any_locked : prot_hit)
					fset = fset | FSR_PROT | FSR_EERR;
				else begin
					go_erase = 1'h1;
					tload    = 1'h1;
					tval     = ers_cyc;
					fclr     = fclr | FSR_PEC;
				end
			end
			if (opc_r == OPC_SUSP && st_r == ST_RUN && !go_end &&
			    cur_kind_r != OP_BE && !late_r) begin
				fset = fset | (cur_is_prog ? FSR_PSUS : FSR_ESUS);
				if (t_rem < {20'h0, LAT_CYC})
					go_late = 1'h1;
				else
					go_lat = 1'h1;
			end
			if (opc_r == OPC_RES && st_r == ST_SUSP) begin
				go_res = 1'h1;
				fclr   = fclr | FSR_PEC | (cur_is_prog ? FSR_PSUS : FSR_ESUS);
			end
			if (opc_r == OPC_CLRF)
				fclr = fclr | FSR_EERR | FSR_PERR | FSR_PROT;
		end
	end

	pe_countdown u_timer (
		.clk      (ref_clk),
		.rst_n    (rst_n),
		.load     (tload),
		.load_val (tval),
		.run      (st_r == ST_RUN),
		.rem      (t_rem),
		.done     (t_done)
	);

	// ----------------------------------------------------------------
	// operation state
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			st_r        <= ST_IDLE;
			cur_kind_r  <= OP_NONE;
			held_kind_r <= OP_NONE;
			cur_addr_r  <= 32'h0;
			held_addr_r <= 32'h0;
			held_rem_r  <= 32'h0;
			held_r      <= 1'h0;
			late_r      <= 1'h0;
			lat_r       <= 12'h0;
		end else if (go_end) begin
			late_r <= 1'h0;
			if (held_r) begin
				st_r       <= ST_SUSP;
				cur_kind_r <= held_kind_r;
				cur_addr_r <= held_addr_r;
				held_r     <= 1'h0;
			end else begin
				st_r       <= ST_IDLE;
				cur_kind_r <= OP_NONE;
			end
		end else if (go_prog) begin
			st_r       <= ST_RUN;
			cur_kind_r <= OP_PROG;
			cur_addr_r <= frame_addr_r;
			if (go_nest) begin
				held_r      <= 1'h1;
				held_kind_r <= cur_kind_r;
				held_addr_r <= cur_addr_r;
				held_rem_r  <= t_rem;
			end
		end else if (go_erase) begin
			st_r       <= ST_RUN;
			cur_kind_r <= ers_kind;
			cur_addr_r <= frame_addr_r;
		end else if (go_lat) begin
			st_r  <= ST_LAT;
			lat_r <= LAT_CYC - 12'h1;
		end else if (go_late) begin
			late_r <= 1'h1;
		end else if (lat_done) begin
			st_r <= ST_SUSP;
		end else if (st_r == ST_LAT) begin
			lat_r <= lat_r - 12'h1;
		end else if (go_res) begin
			st_r <= ST_RUN;
		end
	end

	// ----------------------------------------------------------------
	// status bits
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n)
			fsr_r <= FSR_RST;
		else
			fsr_r <= (fsr_r & ~fclr) | fset; // events win over clears
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n)
			wip_r <= 1'h0;
		else if (go_prog || go_erase || go_res)
			wip_r <= 1'h1;
		else if (go_end || lat_done)
			wip_r <= 1'h0;
	end

	// protection refusals and suspended-sector hits leave the latch alone
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n)
			wel_r <= 1'h0;
		else if (frame_ok && opc_r == OPC_WREN)
			wel_r <= 1'h1;
		else if (go_end || (frame_ok && opc_r == OPC_WRDI))
			wel_r <= 1'h0;
	end

	// strap is caught one cycle after release, never under reset
	logic init_r;

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			init_r  <= 1'h0;
			addr4_r <= 1'h0;
		end else if (!init_r) begin
			init_r  <= 1'h1;
			addr4_r <= nv_addr4;
		end else if (frame_ok && opc_r == OPC_EN4) begin
			addr4_r <= 1'h1;
		end else if (frame_ok && opc_r == OPC_EX4) begin
			addr4_r <= 1'h0;
		end
	end

	// ----------------------------------------------------------------
	// array side
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			array_cmd_r <= '{valid: 1'h0, kind: OP_NONE, addr: 32'h0, fill: 8'h00};
			array_run_r <= 1'h0;
		end else begin
			array_cmd_r.valid <= go_prog || go_erase;
			if (go_prog || go_erase) begin
				array_cmd_r.kind <= go_prog ? OP_PROG : ers_kind;
				array_cmd_r.addr <= frame_addr_r;
				array_cmd_r.fill <= go_erase ? ERASE_FILL : 8'h00;
			end
			if (go_prog || go_erase || go_res)
				array_run_r <= 1'h1;
			else if (go_end || go_lat)
				array_run_r <= 1'h0;
		end
	end
endmodule // nor_program_erase_suspend_ctrl

// ### rtl/pe_countdown.sv
// down counter for self-timed array operations
// assumes load and run come from logic on the same clock
`timescale 1ns/1ps
module pe_countdown (
	input  wire logic        clk,      // sequencer clock
	input  wire logic        rst_n,    // active-low reset
	input  wire logic        load,     // load a new duration
	input  wire logic [31:0] load_val, // duration in cycles
	input  wire logic        run,      // count while high
	output logic      [31:0] rem,      // cycles remaining
	output logic             done      // one-cycle pulse on reaching zero
);
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rem  <= 32'h0;
			done <= 1'h0;
		end else begin
			done <= run && !load && (rem == 32'h1);
			if (load)
				rem <= load_val;
			else if (run && rem != 32'h0)
				rem <= rem - 32'h1;
		end
	end
endmodule // pe_countdown

// ### tb/host_link.sv
// host controller model: sends command frames on the serial link
// assumes the caller runs one frame at a time; sclk parked low between frames
`timescale 1ns/1ps
module host_link
	import nor_pe_pkg::*;
(
	output link_s link // pins toward the device
);
	initial link = LINK_IDLE;
	// n serial bits msb first on dq[0], then nq nibble clocks on dq[3:0]
	task automatic send(input logic [63:0] d, input int n, input int nq);
		link.cs_n = 1'b0;
		for (int i = 0; i < n + nq; i++) begin
			if (i < n) link.dq[0] = d[n - 1 - i];
			else link.dq = 4'hA ^ 4'(i);
			#40 link.sclk = 1'b1;
			#40 link.sclk = 1'b0;
		end
		#40 link.cs_n = 1'b1;
		// released lines must not keep the last value
		link.dq = ~link.dq;
		#200;
	endtask
endmodule // host_link

// ### tb/nor_pe_props.sv
// concurrent checks on the sequencer's status and array start outputs
// assumes it is bound to the sequencer top and sees only its ports
`timescale 1ns/1ps
module nor_pe_props
	import nor_pe_pkg::*;
(
	input wire logic       ref_clk,     // clock
	input wire logic       nrst,        // async reset, low
	input wire logic       wel_r,       // write enable latch
	input wire logic       wip_r,       // write in progress
	input wire logic [7:0] fsr_r,       // flag status
	input wire array_cmd_s array_cmd_r, // array start
	input wire logic       array_run_r  // array advancing
);
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!nrst);
	logic [11:0] halt_cnt_r;

	// latency window too long for a delay range, so it is counted here
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst)
			halt_cnt_r <= 12'h000;
		else if (wip_r && !array_run_r)
			halt_cnt_r <= halt_cnt_r + 12'h001;
		else
			halt_cnt_r <= 12'h000;
	end
	property p_start_busy;
		array_cmd_r.valid |-> wip_r && !fsr_r[7] && array_run_r;
	endproperty
	a_start_busy: assert property (p_start_busy)
		else $error("start without busy status");
	property p_fill;
		array_cmd_r.valid && array_cmd_r.kind != OP_PROG |-> array_cmd_r.fill == 8'hFF;
	endproperty
	a_fill: assert property (p_fill)
		else $error("erase fill not all ones");
	property p_wel_gate;
		array_cmd_r.valid |-> $past(wel_r);
	endproperty
	a_wel_gate: assert property (p_wel_gate)
		else $error("start without write enable");
	property p_end_wel;
		$fell(wip_r) && fsr_r[7] && !fsr_r[6] && !fsr_r[2] |-> !wel_r;
	endproperty
	a_end_wel: assert property (p_end_wel)
		else $error("latch kept after operation end");
	property p_idle_ready;
		!wip_r && !fsr_r[6] && !fsr_r[2] |-> fsr_r[7];
	endproperty
	a_idle_ready: assert property (p_idle_ready)
		else $error("controller busy while idle");
	property p_susp_flag;
		$fell(array_run_r) && wip_r |-> fsr_r[6] || fsr_r[2];
	endproperty
	a_susp_flag: assert property (p_susp_flag)
		else $error("halt without suspend flag");
	property p_susp_lat;
		halt_cnt_r != 12'h000 |-> (wip_r && !array_run_r) ?
			(!fsr_r[7] && halt_cnt_r < LAT_CYC) : (fsr_r[7] && halt_cnt_r == LAT_CYC);
	endproperty
	a_susp_lat: assert property (p_susp_lat)
		else $error("ready flag off suspend latency");
	property p_prot;
		$rose(fsr_r[1]) |-> wel_r && (fsr_r[5] || fsr_r[4]);
	endproperty
	a_prot: assert property (p_prot)
		else $error("protection refusal flags or latch wrong");
	c_prog: cover property (array_cmd_r.valid && array_cmd_r.kind == OP_PROG);
	c_esus: cover property ($rose(fsr_r[6]));
	c_prot: cover property ($rose(fsr_r[1]));
endmodule // nor_pe_props

bind nor_program_erase_suspend_ctrl nor_pe_props nor_pe_props_inst (
	.ref_clk     (ref_clk),
	.nrst        (nrst),
	.wel_r       (wel_r),
	.wip_r       (wip_r),
	.fsr_r       (fsr_r),
	.array_cmd_r (array_cmd_r),
	.array_run_r (array_run_r)
);

// ### tb/nor_program_erase_suspend_ctrl_tb.sv
// self-checking bench of the program/erase/suspend sequencer
// assumes the host model frames commands; array times are shortened
`timescale 1ns/1ps
module nor_program_erase_suspend_ctrl_tb
	import nor_pe_pkg::*;
();
	localparam logic [23:0] A3 = 24'h123456;
	logic        ref_clk;
	logic        nrst;
	link_s       link;
	logic        prot_hit;
	logic        any_locked;
	logic        op_fault;
	logic        wel_r;
	logic        wip_r;
	logic [7:0]  fsr_r;
	logic        addr4_r;
	logic        nv_addr4;
	logic [31:0] frame_addr_r;
	array_cmd_s  array_cmd_r;
	array_cmd_s  last_cmd;
	logic        array_run_r;
	logic [31:0] n_start;
	int          mismatches;
	int          num_checks;

	host_link host_link_inst (.link(link));
	// subsector erase and program longer than the 2000-cycle suspend latency; sector and bulk erase shorter
	nor_program_erase_suspend_ctrl #(
		.PP_CYC  (32'h0BB8),
		.SSE_CYC (32'h1388),
		.SE_CYC  (32'h0258),
		.BE_CYC  (32'h0320)
	) nor_program_erase_suspend_ctrl_inst (
		.ref_clk      (ref_clk),
		.nrst         (nrst),
		.link         (link),
		.nv_addr4     (nv_addr4),
		.prot_hit     (prot_hit),
		.any_locked   (any_locked),
		.op_fault     (op_fault),
		.wel_r        (wel_r),
		.wip_r        (wip_r),
		.fsr_r        (fsr_r),
		.addr4_r      (addr4_r),
		.frame_addr_r (frame_addr_r),
		.array_cmd_r  (array_cmd_r),
		.array_run_r  (array_run_r)
	);

	always @(posedge ref_clk) begin
		if (array_cmd_r.valid === 1'b1) begin
			last_cmd <= array_cmd_r;
			n_start <= n_start + 1;
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("CHECK FAILED %0t ns: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic fr(input logic [63:0] d, input int n, input int nq = 0);
		host_link_inst.send(d, n, nq);
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask
	task automatic wait_idle();
		for (int i = 0; i < 9000 && wip_r !== 1'b0; i++) cyc(1);
		chk(32'(wip_r), 32'h0);
	endtask
	task automatic report_and_stop();
		if (mismatches == 0 && num_checks > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic t_no_wel();
		chk(32'({wel_r, wip_r, addr4_r, fsr_r}), 32'(FSR_RST));
		fr(64'({OPC_SSE, A3}), 32);
		chk(n_start, 32'h0);
		chk(32'(fsr_r), 32'(FSR_RST));
	endtask
	task automatic t_erase_kinds();
		logic [7:0] ops [5] = '{OPC_SSE2, OPC_SSE, OPC_SE, OPC_BE, OPC_BE2};
		op_kind_e   kinds [5] = '{OP_SSE, OP_SSE, OP_SE, OP_BE, OP_BE};
		for (int i = 0; i < 5; i++) begin
			fr(64'(OPC_WREN), 8);
			if (kinds[i] == OP_BE) fr(64'(ops[i]), 8);
			else fr(64'({ops[i], A3}), 32);
			chk(32'(last_cmd.kind), 32'(kinds[i]));
			chk(last_cmd.addr, (kinds[i] == OP_BE) ? 32'h0 : 32'(A3));
			chk(32'(last_cmd.fill), 32'(ERASE_FILL));
			chk(32'({wip_r, fsr_r[7]}), 32'h2);
			wait_idle();
			chk(32'({wel_r, fsr_r}), 32'(FSR_RST));
		end
	endtask
	task automatic t_prog();
		fr(64'(OPC_EN4), 8);
		chk(32'(addr4_r), 32'h1);
		fr(64'(OPC_WREN), 8);
		fr(64'({OPC_PP3, 32'hA1B2C3D4, 8'h5A}), 48);
		chk(last_cmd.addr, 32'hA1B2C3D4);
		chk(32'(last_cmd.kind), 32'(OP_PROG));
		wait_idle();
		fr(64'(OPC_EX4), 8);
		chk(32'(addr4_r), 32'h0);
		fr(64'(OPC_WREN), 8);
		fr(64'({OPC_PP4, 32'h0ECA1357, 8'hC3}), 48);
		chk(last_cmd.addr, 32'h0ECA1357);
		wait_idle();
		fr(64'(OPC_WREN), 8);
		fr(64'({OPC_QP4, 32'h0BAD0F0E}), 40, 2);
		chk(last_cmd.addr, 32'h0BAD0F0E);
		chk(frame_addr_r, 32'h0BAD0F0E);
		wait_idle();
	endtask
	task automatic t_refusals();
		logic [31:0] s0;
		fr(64'(OPC_WREN), 8);
		s0 = n_start;
		fr(64'({OPC_SSE, A3, 3'h5}), 35);
		chk(n_start, s0);
		chk(32'({wel_r, fsr_r}), 32'({1'b1, FSR_RST}));
		prot_hit = 1'b1;
		fr(64'({OPC_SE, A3}), 32);
		chk(32'({wel_r, fsr_r}), 32'({1'b1, FSR_RST | FSR_PROT | FSR_EERR}));
		prot_hit = 1'b0;
		fr(64'(OPC_CLRF), 8);
		chk(32'(fsr_r), 32'(FSR_RST));
		any_locked = 1'b1;
		fr(64'(OPC_BE), 8);
		chk(32'({wel_r, fsr_r}), 32'({1'b1, FSR_RST | FSR_PROT | FSR_EERR}));
		any_locked = 1'b0;
		fr(64'({OPC_SE, A3}), 32);
		cyc(1);
		op_fault = 1'b1;
		cyc(1);
		op_fault = 1'b0;
		wait_idle();
		chk(32'({wel_r, fsr_r}), 32'(FSR_RST | FSR_EERR | FSR_PROT));
		fr(64'(OPC_CLRF), 8);
	endtask
	task automatic t_suspend();
		fr(64'(OPC_WREN), 8);
		fr(64'({OPC_SSE, A3}), 32);
		fr(64'(OPC_SUSP), 8);
		chk(32'({array_run_r, wip_r, fsr_r}), 32'h140);
		for (int i = 0; i < 2100 && fsr_r[7] !== 1'b1; i++) cyc(1);
		cyc(2);
		chk(32'({wip_r, fsr_r}), 32'(FSR_PEC | FSR_ESUS));
		fr(64'(OPC_WREN), 8);
		fr(64'({OPC_PP4, 32'h00120000, 8'h11}), 48);
		chk(32'({wel_r, fsr_r}), 32'({1'b1, FSR_PEC | FSR_ESUS | FSR_PERR}));
		fr(64'(OPC_CLRF), 8);
		fr(64'({OPC_PP4, 32'h00340000, 8'h22}), 48);
		chk(32'(last_cmd.kind), 32'(OP_PROG));
		wait_idle();
		chk(32'({wel_r, fsr_r}), 32'(FSR_PEC | FSR_ESUS));
		fr(64'(OPC_RES), 8);
		chk(32'({array_run_r, wip_r, fsr_r}), 32'h300);
		wait_idle();
		chk(32'(fsr_r), 32'(FSR_RST));
		fr(64'(OPC_RES), 8);
		chk(32'({wip_r, fsr_r}), 32'(FSR_RST));
	endtask
	task automatic t_late();
		fr(64'(OPC_WREN), 8);
		fr(64'({OPC_SSE, A3}), 32);
		cyc(3500);
		fr(64'(OPC_SUSP), 8);
		chk(32'({array_run_r, fsr_r}), 32'h140);
		wait_idle();
		chk(32'(fsr_r), 32'(FSR_RST));
	endtask
	task automatic t_strap();
		fr(64'(OPC_WREN), 8);
		fr(64'({OPC_SSE, A3}), 32);
		fr(64'(OPC_SUSP), 8);
		nv_addr4 = 1'b1;
		nrst = 1'b0;
		cyc(3);
		nrst = 1'b1;
		cyc(20);
		chk(32'({wel_r, wip_r, addr4_r, array_run_r, fsr_r}), 32'({4'h2, FSR_RST}));
		fr(64'(OPC_WREN), 8);
		fr(64'({OPC_SSE, 32'h00ABCDEF}), 40);
		chk(last_cmd.addr, 32'h00ABCDEF);
		wait_idle();
	endtask

	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end
	initial begin
		nrst = 1'b0;
		nv_addr4 = 1'b0;
		prot_hit = 1'b0;
		any_locked = 1'b0;
		op_fault = 1'b0;
		n_start = 32'h0;
		mismatches = 0;
		num_checks = 0;
		repeat (3) @(posedge ref_clk);
		#1;
		nrst = 1'b1;
		cyc(20);
		t_no_wel();
		t_erase_kinds();
		t_prog();
		t_refusals();
		t_suspend();
		t_late();
		t_strap();
		report_and_stop();
	end
	// runs take some 50k cycles; nearly twice that means a hang
	initial begin
		#900000;
		mismatches++;
		report_and_stop();
	end
endmodule // nor_program_erase_suspend_ctrl_tb
